// file: include/bcd_adc_regs.svh
`ifndef BCD_ADC_REGS_SVH
`define BCD_ADC_REGS_SVH
// ==========================================================
// register offsets (byte addresses on the register bus)
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_FLAGS 8'h08
`define OFS_MEM 8'h0c
`define OFS_GPR 8'h20
// ==========================================================
// field positions and reset values
`define CTRL_NARROW 0
`define STAT_BUSY 0
`define STAT_UNSUP 1
`define FLAG_CF 0
`define FLAG_PF 2
`define FLAG_AF 4
`define FLAG_ZF 6
`define FLAG_SF 7
`define FLAG_TF 8
`define FLAG_IF 9
`define FLAG_DF 10
`define FLAG_OF 11
`define FLAGS_RST 16'h0000
`define WORD_RST 16'h0000
// ==========================================================
// opcode bytes
`define OPC_AAA 8'h37
`define OPC_AAS 8'h3f
`define OPC_AAD 8'hd5
`define OPC_AAD_BASE 8'h0a
`define OPC_ADC_AL 8'h14
`define OPC_ADC_AX 8'h15
`define OPC_GRP_B 8'h80
`define OPC_GRP_W 8'h81
`define OPC_GRP_SX 8'h83
`define EXT_ADC 3'h2
// ==========================================================
// execution times in core clocks
`define CYC_AAA 5'h08
`define CYC_AAD 5'h0f
`define CYC_AAS 5'h07
`define CYC_ADC_AL 5'h03
`define CYC_ADC_AX 5'h04
`define CYC_RM_REG 5'h04
`define CYC_RM_MEM 5'h10
`define CYC_RM_MEM_NARROW 5'h14
// ==========================================================
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: include/bcd_adc_pkg.sv
package bcd_adc_pkg;
	// ==========================================================
	// decoder states, one-hot
	typedef enum logic [5:0] {
		S_OP = 6'h01,
		S_BASE = 6'h02,
		S_MODRM = 6'h04,
		S_DISP = 6'h08,
		S_IMM = 6'h10,
		S_EXEC = 6'h20
	} dec_state_t;
	// decoded operation
	typedef enum logic [2:0] {
		OP_AAA = 3'h0,
		OP_AAD = 3'h1,
		OP_AAS = 3'h2,
		OP_ADC_AL = 3'h3,
		OP_ADC_AX = 3'h4,
		OP_ADC_RM8 = 3'h5,
		OP_ADC_RM16 = 3'h6,
		OP_ADC_SX = 3'h7
	} op_t;
	// adder result with its status bits
	typedef struct packed {
		logic [15:0] value;
		logic ovf;
		logic sgn;
		logic zer;
		logic aux;
		logic par;
		logic cry;
	} arith_t;
endpackage : bcd_adc_pkg

// file: verilog/bcd_adc_core.sv
// Function
// [RULE1] opcode 37: adjust after add, 8 clocks
// [RULE2] after-add adjust writes aux-carry and carry only
// [RULE3] bytes D5 0A: adjust before divide, 15 clocks
// [RULE4] before-divide adjust writes sign, zero, parity
// [RULE5] opcode 3F: adjust after subtract, 7 clocks
// [RULE6] after-subtract adjust keeps direction, interrupt, trap
// [RULE7] opcode 14 plus byte: add with carry, 3
// [RULE8] add with carry writes six arithmetic flags
// [RULE9] opcode 15 plus word: add with carry, 4
// [RULE10] 80 /2: byte operand add, 4 or 16
// [RULE11] 81 /2: word operand, 4/16 or 4/20
// [RULE12] 83 /2: sign-extended byte to word operand
// [RULE13] extension digit is the middle addressing-byte field
// [RULE14] first count for register, second for memory
`include "bcd_adc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module bcd_adc_core (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic fetch_valid_in,
	input wire logic [7:0] fetch_byte_in,
	output logic fetch_ready_out,
	output logic exec_done_out,
	input wire logic [7:0] axi_awaddr_in,
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	output logic [1:0] axi_bresp_out,
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	input wire logic [7:0] axi_araddr_in,
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	output logic [31:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out,
	output logic axi_rvalid_out,
	input wire logic axi_rready_in
);
	// ==========================================================
	// reset release
	logic rst_n_meta_q, rst_n_q; // second stage is the design reset
	// async assert, two-stage release
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_n_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_n_meta_q <= 1'b1;
			rst_n_q <= rst_n_meta_q;
		end
	end
	// ==========================================================
	// helpers
	function automatic logic even_par(input logic [7:0] v);
		return ~^v;
	endfunction : even_par
	function automatic bcd_adc_pkg::arith_t adc_calc(input logic [15:0] a,
			input logic [15:0] b, input logic cin, input logic wide);
		bcd_adc_pkg::arith_t r;
		logic [16:0] s;
		logic [8:0] sb;
		s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
		sb = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
		r.value = wide ? s[15:0] : {8'h00, sb[7:0]};
		r.cry = wide ? s[16] : sb[8];
		r.aux = a[4] ^ b[4] ^ s[4];
		r.sgn = wide ? s[15] : sb[7];
		r.zer = wide ? (s[15:0] == 16'h0000) : (sb[7:0] == 8'h00);
		r.ovf = wide ? (a[15] == b[15] && s[15] != a[15])
			: (a[7] == b[7] && sb[7] != a[7]);
		r.par = even_par(s[7:0]);
		return r;
	endfunction : adc_calc
	// all six arithmetic flags from one adder result
	function automatic logic [15:0] set_arith(input logic [15:0] f,
			input bcd_adc_pkg::arith_t r);
		logic [15:0] n;
		n = f;
		n[`FLAG_OF] = r.ovf;
		n[`FLAG_SF] = r.sgn;
		n[`FLAG_ZF] = r.zer;
		n[`FLAG_AF] = r.aux;
		n[`FLAG_PF] = r.par;
		n[`FLAG_CF] = r.cry;
		return n;
	endfunction : set_arith
	// byte lanes 0 and 1 carry the 16-bit registers
	function automatic logic [15:0] merge(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] strb);
		return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction : merge
	function automatic logic is_mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && (a <= `OFS_MEM
			|| (a >= `OFS_GPR && a <= `OFS_GPR + 8'h1c));
	endfunction : is_mapped
	// ==========================================================
	// decoder and cycle timer
	bcd_adc_pkg::dec_state_t state_q, state_d;
	bcd_adc_pkg::op_t op_q, op_d;
	logic [1:0] mod_q, mod_d; // addressing mode of the operand
	logic [2:0] rm_q, rm_d; // register or memory selector
	logic [7:0] opcode_q, opcode_d; // last opcode taken
	logic [15:0] imm_q, imm_d;
	logic [1:0] disp_left_q, disp_left_d;
	logic [1:0] imm_left_q, imm_left_d;
	logic [4:0] cnt_q, cnt_d; // clocks left in execution
	logic done_q, done_d;
	logic ready_q, ready_d;
	logic narrow_q; // 8-bit bus variant selected
	logic take, launch, unsup_ev, wb_en;
	logic [4:0] cyc;
	assign take = fetch_valid_in && ready_q;
	assign wb_en = state_q == bcd_adc_pkg::S_EXEC && cnt_q == 5'h00;
	// next-state decode, one byte per accepted transfer
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		mod_d = mod_q;
		rm_d = rm_q;
		opcode_d = opcode_q;
		imm_d = imm_q;
		disp_left_d = disp_left_q;
		imm_left_d = imm_left_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		launch = 1'b0;
		unsup_ev = 1'b0;
		case (state_q)
			bcd_adc_pkg::S_OP: begin
				if (take) begin
					opcode_d = fetch_byte_in;
					imm_d = 16'h0000;
					mod_d = 2'b11;
					case (fetch_byte_in)
						`OPC_AAA: begin
							op_d = bcd_adc_pkg::OP_AAA; // RULE1
							launch = 1'b1;
						end
						`OPC_AAS: begin
							op_d = bcd_adc_pkg::OP_AAS; // RULE5
							launch = 1'b1;
						end
						`OPC_AAD: begin
							op_d = bcd_adc_pkg::OP_AAD;
							state_d = bcd_adc_pkg::S_BASE;
						end
						`OPC_ADC_AL: begin
							op_d = bcd_adc_pkg::OP_ADC_AL; // RULE7
							imm_left_d = 2'h1;
							state_d = bcd_adc_pkg::S_IMM;
						end
						`OPC_ADC_AX: begin
							op_d = bcd_adc_pkg::OP_ADC_AX; // RULE9
							imm_left_d = 2'h2;
							state_d = bcd_adc_pkg::S_IMM;
						end
						`OPC_GRP_B, `OPC_GRP_W, `OPC_GRP_SX: begin
							state_d = bcd_adc_pkg::S_MODRM;
						end
						// anything else is not handled here
						default: unsup_ev = 1'b1;
					endcase
				end
			end
			bcd_adc_pkg::S_BASE: begin
				if (take) begin
					if (fetch_byte_in == `OPC_AAD_BASE) begin
						launch = 1'b1; // RULE3
					end else begin
						unsup_ev = 1'b1;
						state_d = bcd_adc_pkg::S_OP;
					end
				end
			end
			bcd_adc_pkg::S_MODRM: begin
				// limitation: after a refused extension the rest of
				// that instruction is read as fresh opcodes
				if (take && fetch_byte_in[5:3] != `EXT_ADC) begin
					unsup_ev = 1'b1; // RULE13
					state_d = bcd_adc_pkg::S_OP;
				end else if (take) begin
					mod_d = fetch_byte_in[7:6];
					rm_d = fetch_byte_in[2:0];
					case (opcode_q)
						`OPC_GRP_B: op_d = bcd_adc_pkg::OP_ADC_RM8; // RULE10
						`OPC_GRP_W: op_d = bcd_adc_pkg::OP_ADC_RM16; // RULE11
						default: op_d = bcd_adc_pkg::OP_ADC_SX; // RULE12
					endcase
					imm_left_d = opcode_q == `OPC_GRP_W ? 2'h2 : 2'h1;
					// displacement bytes are skipped, memory is one word
					if (fetch_byte_in[7:6] == 2'b01) begin
						disp_left_d = 2'h1;
					end else if (fetch_byte_in[7:6] == 2'b10 || (fetch_byte_in[7:6]
							== 2'b00 && fetch_byte_in[2:0] == 3'h6)) begin
						disp_left_d = 2'h2;
					end else begin
						disp_left_d = 2'h0;
					end
					state_d = disp_left_d != 2'h0 ? bcd_adc_pkg::S_DISP
						: bcd_adc_pkg::S_IMM;
				end
			end
			bcd_adc_pkg::S_DISP: begin
				if (take) begin
					disp_left_d = disp_left_q - 2'h1;
					if (disp_left_q == 2'h1) begin
						state_d = bcd_adc_pkg::S_IMM;
					end
				end
			end
			bcd_adc_pkg::S_IMM: begin
				if (take) begin
					// low byte arrives first
					if (imm_left_q == 2'h2 || op_q != bcd_adc_pkg::OP_ADC_AX
							&& op_q != bcd_adc_pkg::OP_ADC_RM16) begin
						imm_d[7:0] = fetch_byte_in;
					end else begin
						imm_d[15:8] = fetch_byte_in;
					end
					imm_left_d = imm_left_q - 2'h1;
					launch = imm_left_q == 2'h1;
				end
			end
			bcd_adc_pkg::S_EXEC: begin
				cnt_d = cnt_q - 5'h01;
				if (cnt_q == 5'h00) begin
					done_d = 1'b1;
					state_d = bcd_adc_pkg::S_OP;
				end
			end
			default: state_d = bcd_adc_pkg::S_OP;
		endcase
		// pick the execution time; memory forms take the second count
		case (op_d)
			bcd_adc_pkg::OP_AAA: cyc = `CYC_AAA;
			bcd_adc_pkg::OP_AAD: cyc = `CYC_AAD;
			bcd_adc_pkg::OP_AAS: cyc = `CYC_AAS;
			bcd_adc_pkg::OP_ADC_AL: cyc = `CYC_ADC_AL;
			bcd_adc_pkg::OP_ADC_AX: cyc = `CYC_ADC_AX;
			bcd_adc_pkg::OP_ADC_RM8: begin
				cyc = mod_d == 2'b11 ? `CYC_RM_REG : `CYC_RM_MEM; // RULE14
			end
			default: begin
				cyc = mod_d == 2'b11 ? `CYC_RM_REG
					: narrow_q ? `CYC_RM_MEM_NARROW : `CYC_RM_MEM; // RULE14
			end
		endcase
		if (launch) begin
			state_d = bcd_adc_pkg::S_EXEC;
			cnt_d = cyc - 5'h01;
		end
		ready_d = state_d != bcd_adc_pkg::S_EXEC;
	end
	// decoder registers, frozen while the clock enable is low
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= bcd_adc_pkg::S_OP;
			op_q <= bcd_adc_pkg::OP_AAA;
			mod_q <= 2'b11;
			rm_q <= 3'h0;
			opcode_q <= 8'h00;
			imm_q <= 16'h0000;
			disp_left_q <= 2'h0;
			imm_left_q <= 2'h0;
			cnt_q <= 5'h00;
			done_q <= 1'b0;
			ready_q <= 1'b1;
		end else if (ce_in) begin
			state_q <= state_d;
			op_q <= op_d;
			mod_q <= mod_d;
			rm_q <= rm_d;
			opcode_q <= opcode_d;
			imm_q <= imm_d;
			disp_left_q <= disp_left_d;
			imm_left_q <= imm_left_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			ready_q <= ready_d;
		end
	end
	assign fetch_ready_out = ready_q;
	assign exec_done_out = done_q;
	// ==========================================================
	// register bus slave
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0] waddr_q, waddr_d, raddr;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic bus_wr; // write takes effect this cycle
	logic unsup_q;
	logic [15:0] flags_q, mem_q, regs_q [8];
	assign bus_wr = aw_full_q && w_full_q && !bvalid_q;
	assign raddr = axi_araddr_in;
	// handshakes; address and data may arrive in either order
	always_comb begin
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q && !axi_bready_in;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !axi_rready_in;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (axi_awvalid_in && awready_q) begin
			aw_full_d = 1'b1;
			waddr_d = axi_awaddr_in;
		end
		if (axi_wvalid_in && wready_q) begin
			w_full_d = 1'b1;
			wdata_d = axi_wdata_in;
			wstrb_d = axi_wstrb_in;
		end
		if (bus_wr) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = is_mapped(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (axi_arvalid_in && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = is_mapped(raddr) ? `RESP_OKAY : `RESP_SLVERR;
			case (raddr)
				`OFS_CTRL: rdata_d = {31'h0, narrow_q};
				`OFS_STATUS: rdata_d = {16'h0, opcode_q, 6'h00, unsup_q,
					state_q != bcd_adc_pkg::S_OP};
				`OFS_FLAGS: rdata_d = {16'h0, flags_q};
				`OFS_MEM: rdata_d = {16'h0, mem_q};
				default: rdata_d = is_mapped(raddr) ? {16'h0, regs_q[raddr[4:2]]}
					: 32'h0;
			endcase
		end
		awready_d = !aw_full_d;
		wready_d = !w_full_d;
		arready_d = !rvalid_d;
	end
	// bus registers run even with the enable low, so software can
	// still reach a frozen core
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			{aw_full_q, w_full_q, bvalid_q, rvalid_q} <= 4'h0;
			{awready_q, wready_q, arready_q} <= 3'h0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			rdata_q <= 32'h0;
			bresp_q <= `RESP_OKAY;
			rresp_q <= `RESP_OKAY;
		end else begin
			{aw_full_q, w_full_q, bvalid_q, rvalid_q} <=
				{aw_full_d, w_full_d, bvalid_d, rvalid_d};
			{awready_q, wready_q, arready_q} <= {awready_d, wready_d, arready_d};
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			rdata_q <= rdata_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
		end
	end
	assign axi_awready_out = awready_q;
	assign axi_wready_out = wready_q;
	assign axi_bvalid_out = bvalid_q;
	assign axi_bresp_out = bresp_q;
	assign axi_arready_out = arready_q;
	assign axi_rvalid_out = rvalid_q;
	assign axi_rresp_out = rresp_q;
	assign axi_rdata_out = rdata_q;
	// ==========================================================
	// architectural state: registers, flags, memory word, status
	logic narrow_d, unsup_d, adj;
	logic [15:0] flags_d, mem_d, regs_d [8], dst, src;
	logic [7:0] al_n, ah_n, dst_b;
	bcd_adc_pkg::arith_t r;
	// bus writes first, execution results override them
	always_comb begin
		narrow_d = narrow_q;
		flags_d = flags_q;
		mem_d = mem_q;
		regs_d = regs_q;
		unsup_d = unsup_q;
		if (bus_wr) begin
			case (waddr_q)
				`OFS_CTRL: narrow_d = wstrb_q[0] ? wdata_q[`CTRL_NARROW] : narrow_q;
				`OFS_STATUS: begin
					if (wstrb_q[0] && wdata_q[`STAT_UNSUP]) unsup_d = 1'b0;
				end
				`OFS_FLAGS: flags_d = merge(flags_q, wdata_q, wstrb_q);
				`OFS_MEM: mem_d = merge(mem_q, wdata_q, wstrb_q);
				default: begin
					if (is_mapped(waddr_q)) begin
						regs_d[waddr_q[4:2]] = merge(regs_q[waddr_q[4:2]], wdata_q,
							wstrb_q);
					end
				end
			endcase
		end
		if (unsup_ev && ce_in) unsup_d = 1'b1; // set beats clear
		adj = regs_q[0][3:0] > 4'h9 || flags_q[`FLAG_AF];
		dst = mod_q != 2'b11 ? mem_q : regs_q[rm_q];
		dst_b = mod_q != 2'b11 ? mem_q[7:0] : rm_q[2]
			? regs_q[{1'b0, rm_q[1:0]}][15:8] : regs_q[{1'b0, rm_q[1:0]}][7:0];
		src = op_q == bcd_adc_pkg::OP_ADC_SX ? {{8{imm_q[7]}}, imm_q[7:0]}
			: imm_q;
		al_n = regs_q[0][7:0];
		ah_n = regs_q[0][15:8];
		r = adc_calc(dst, src, flags_q[`FLAG_CF], 1'b1);
		// a bus write during a freeze must not retire the instruction
		if (wb_en && ce_in) begin
			// undefined flags are left as they were; D, I, T never move
			case (op_q)
				bcd_adc_pkg::OP_AAA, bcd_adc_pkg::OP_AAS: begin
					if (adj && op_q == bcd_adc_pkg::OP_AAA) begin
						al_n = al_n + 8'h06;
						ah_n = ah_n + 8'h01;
					end else if (adj) begin
						al_n = al_n - 8'h06;
						ah_n = ah_n - 8'h01;
					end
					regs_d[0] = {ah_n, 4'h0, al_n[3:0]};
					flags_d[`FLAG_AF] = adj; // RULE2 RULE6
					flags_d[`FLAG_CF] = adj; // RULE2 RULE6
				end
				bcd_adc_pkg::OP_AAD: begin
					al_n = 8'({ah_n, 3'h0} + {ah_n, 1'b0} + al_n);
					regs_d[0] = {8'h00, al_n};
					flags_d[`FLAG_SF] = al_n[7]; // RULE4
					flags_d[`FLAG_ZF] = al_n == 8'h00; // RULE4
					flags_d[`FLAG_PF] = even_par(al_n); // RULE4
				end
				bcd_adc_pkg::OP_ADC_AL: begin
					r = adc_calc({8'h00, al_n}, imm_q, flags_q[`FLAG_CF], 1'b0);
					regs_d[0][7:0] = r.value[7:0];
					flags_d = set_arith(flags_q, r); // RULE8
				end
				bcd_adc_pkg::OP_ADC_AX: begin
					r = adc_calc(regs_q[0], imm_q, flags_q[`FLAG_CF], 1'b1);
					regs_d[0] = r.value;
					flags_d = set_arith(flags_q, r); // RULE8
				end
				bcd_adc_pkg::OP_ADC_RM8: begin
					r = adc_calc({8'h00, dst_b}, imm_q, flags_q[`FLAG_CF], 1'b0);
					flags_d = set_arith(flags_q, r); // RULE8
					if (mod_q != 2'b11) begin
						mem_d[7:0] = r.value[7:0];
					end else if (rm_q[2]) begin
						regs_d[{1'b0, rm_q[1:0]}][15:8] = r.value[7:0];
					end else begin
						regs_d[{1'b0, rm_q[1:0]}][7:0] = r.value[7:0];
					end
				end
				default: begin
					flags_d = set_arith(flags_q, r); // RULE8
					if (mod_q != 2'b11) mem_d = r.value;
					else regs_d[rm_q] = r.value;
				end
			endcase
		end
	end
	// only the enable freezes execution; bus writes still land
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			narrow_q <= 1'b0;
			unsup_q <= 1'b0;
			flags_q <= `FLAGS_RST;
			mem_q <= `WORD_RST;
			for (int i = 0; i < 8; i++) regs_q[i] <= `WORD_RST;
		end else if (ce_in || bus_wr) begin
			narrow_q <= narrow_d;
			unsup_q <= unsup_d;
			flags_q <= flags_d;
			mem_q <= mem_d;
			regs_q <= regs_d;
		end
	end
	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_q);
	logic in_exec;
	assign in_exec = state_q == bcd_adc_pkg::S_EXEC;
	sequence start_s(bcd_adc_pkg::op_t o);
		launch && ce_in && op_d == o;
	endsequence
	aaa_count_a: assert property ( // RULE1
		$rose(in_exec) && op_q == bcd_adc_pkg::OP_AAA |-> cnt_q == 5'h07)
		else $error("adjust after add not loaded with 8 clocks");
	aaa_flags_a: assert property ( // RULE2
		done_q && op_q == bcd_adc_pkg::OP_AAA |-> flags_q[`FLAG_AF]
		== flags_q[`FLAG_CF] && $stable(flags_q[10:8]))
		else $error("adjust after add flags wrong");
	aad_count_a: assert property ( // RULE3
		$rose(in_exec) && op_q == bcd_adc_pkg::OP_AAD |-> cnt_q == 5'h0e)
		else $error("adjust before divide not loaded with 15 clocks");
	aad_flags_a: assert property ( // RULE4
		done_q && op_q == bcd_adc_pkg::OP_AAD |-> regs_q[0][15:8] == 8'h00
		&& flags_q[`FLAG_ZF] == (regs_q[0][7:0] == 8'h00)
		&& flags_q[`FLAG_PF] == ~^regs_q[0][7:0])
		else $error("adjust before divide result or flags wrong");
	aas_time_a: assert property ( // RULE5
		start_s(bcd_adc_pkg::OP_AAS) ##1 ce_in [*7] |=> done_q)
		else $error("adjust after subtract not done in 7 clocks");
	aas_keep_a: assert property ( // RULE6
		done_q && op_q == bcd_adc_pkg::OP_AAS |-> $stable(flags_q[10:8])
		&& flags_q[`FLAG_AF] == flags_q[`FLAG_CF])
		else $error("adjust after subtract touched control flags");
	adc_al_time_a: assert property ( // RULE7
		start_s(bcd_adc_pkg::OP_ADC_AL) ##1 ce_in [*3] |=> done_q)
		else $error("byte add with carry not done in 3 clocks");
	adc_flags_a: assert property ( // RULE8
		done_q && op_q == bcd_adc_pkg::OP_ADC_AL |-> flags_q[`FLAG_ZF]
		== (regs_q[0][7:0] == 8'h00) && flags_q[`FLAG_SF] == regs_q[0][7]
		&& $stable(flags_q[10:8]))
		else $error("add with carry flags wrong");
	adc_ax_time_a: assert property ( // RULE9
		start_s(bcd_adc_pkg::OP_ADC_AX) ##1 ce_in [*4] |=> done_q)
		else $error("word add with carry not done in 4 clocks");
	rm8_count_a: assert property ( // RULE10
		$rose(in_exec) && op_q == bcd_adc_pkg::OP_ADC_RM8 |-> cnt_q
		== (mod_q == 2'b11 ? 5'h03 : 5'h0f))
		else $error("byte operand clock count wrong");
	rm16_count_a: assert property ( // RULE11
		$rose(in_exec) && op_q == bcd_adc_pkg::OP_ADC_RM16 |-> cnt_q
		== (mod_q == 2'b11 ? 5'h03 : $past(narrow_q) ? 5'h13 : 5'h0f))
		else $error("word operand clock count wrong");
	sext_count_a: assert property ( // RULE12
		$rose(in_exec) && op_q == bcd_adc_pkg::OP_ADC_SX |-> cnt_q
		== (mod_q == 2'b11 ? 5'h03 : $past(narrow_q) ? 5'h13 : 5'h0f))
		else $error("sign-extended operand clock count wrong");
	ext_field_a: assert property ( // RULE13
		state_q == bcd_adc_pkg::S_MODRM && take && ce_in
		&& fetch_byte_in[5:3] != 3'h2 |=> unsup_q)
		else $error("wrong extension field not refused");
endmodule : bcd_adc_core
`default_nettype wire

// file: verification/fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// fetch queue: offers queued bytes in order, one per taken edge
module fetch_model (
	input wire logic clk_in,
	input wire logic ready_in,
	input wire logic ce_in,
	output logic valid_out,
	output logic [7:0] byte_out
);
	logic [7:0] q[$]; // bytes pushed by the bench
	initial valid_out = 1'b0;
	initial byte_out = 8'h00;
	// a byte stands until taken; an idle line toggles so stale data shows
	always @(posedge clk_in) begin
		if (valid_out && ready_in && ce_in) begin
			void'(q.pop_front());
		end
		if (q.size() > 0) begin
			valid_out <= 1'b1;
			byte_out <= q[0];
		end else begin
			valid_out <= 1'b0;
			byte_out <= ~byte_out;
		end
	end
endmodule : fetch_model
`default_nettype wire

// file: verification/test_bcd_adjust_add_carry_decode.sv
`include "bcd_adc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_bcd_adjust_add_carry_decode;
	// ==========================================================
	// signals
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic ce_in = 1'b1; // freeze path left untested
	logic fv, fr, done, awv = 1'b0, wv = 1'b0, arv = 1'b0;
	logic awr, wr, bv, arr, rv;
	logic [7:0] fb, awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd_q;
	logic [1:0] br, rr;
	int errors = 0, comparisons = 0, cycles = 0;
	initial forever #4 clk_in = ~clk_in;
	fetch_model FM (.clk_in(clk_in), .ready_in(fr), .ce_in(ce_in),
		.valid_out(fv), .byte_out(fb));
	bcd_adc_core DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
		.fetch_valid_in(fv), .fetch_byte_in(fb), .fetch_ready_out(fr),
		.exec_done_out(done), .axi_awaddr_in(awa), .axi_awvalid_in(awv),
		.axi_awready_out(awr), .axi_wdata_in(wd), .axi_wstrb_in(4'h3),
		.axi_wvalid_in(wv), .axi_wready_out(wr), .axi_bresp_out(br),
		.axi_bvalid_out(bv), .axi_bready_in(1'b1), .axi_araddr_in(ara),
		.axi_arvalid_in(arv), .axi_arready_out(arr), .axi_rdata_out(rd_q),
		.axi_rresp_out(rr), .axi_rvalid_out(rv), .axi_rready_in(1'b1));
	// ==========================================================
	// tasks; bready and rready stay high, which any slave accepts
	task automatic complete_run;
		if (errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [15:0] d);
		awa <= a;
		wd <= {16'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
		end while (!bv);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arv && arr) arv <= 1'b0;
		end while (!rv);
		d = rd_q;
		r = rr;
	endtask : axr
	// ==========================================================
	// expected results: {result, flags}
	function automatic logic [31:0] adc_f(input logic [15:0] a, b, f,
		input logic w);
		logic [16:0] s;
		logic sg;
		s = w ? a + b + f[`FLAG_CF] : a[7:0] + b[7:0] + f[`FLAG_CF];
		sg = w ? s[15] : s[7];
		f[`FLAG_CF] = w ? s[16] : s[8];
		f[`FLAG_OF] = (w ? a[15] == b[15] : a[7] == b[7]) && sg != (w ? a[15] : a[7]);
		f[`FLAG_SF] = sg;
		f[`FLAG_ZF] = w ? s[15:0] == 16'h0 : s[7:0] == 8'h0;
		f[`FLAG_AF] = a[4] ^ b[4] ^ s[4];
		f[`FLAG_PF] = ~^s[7:0];
		return {w ? s[15:0] : {a[15:8], s[7:0]}, f};
	endfunction : adc_f
	// {accumulator, memory word, flags}
	function automatic logic [47:0] exp_f(input int k,
		input logic [15:0] a, m, b, f);
		logic adj;
		adj = a[3:0] > 4'h9 || f[`FLAG_AF];
		if (k < 2) begin
			if (adj) begin
				a[15:8] = a[15:8] + ((k == 0) ? 8'h01 : 8'hff);
				a[7:0] = a[7:0] + ((k == 0) ? 8'h06 : 8'hfa);
			end
			a[7:4] = 4'h0;
			f[`FLAG_AF] = adj;
			f[`FLAG_CF] = adj;
		end else if (k == 2) begin
			a = {8'h00, a[7:0] + a[15:8] * 8'h0a};
			f[`FLAG_SF] = a[7];
			f[`FLAG_ZF] = a[7:0] == 8'h00;
			f[`FLAG_PF] = ~^a[7:0];
		end else if (k == 7) begin
			return {a, adc_f(m, b, f, 1'b1)};
		end else begin
			{a, f} = adc_f(a, b, f, k == 4 || k == 6);
		end
		return {a, m, f};
	endfunction : exp_f
	// ==========================================================
	// run limit
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		logic [7:0] opc[8] = '{8'h37, 8'h3f, 8'hd5, 8'h14, 8'h15, 8'h80, 8'h83, 8'h81};
		int nc[8] = '{8, 7, 15, 3, 4, 4, 4, 16};
		logic [15:0] a, m, b, f;
		logic [47:0] e;
		logic [31:0] d;
		logic [1:0] r;
		logic nar;
		int n;
		void'($urandom(32'he6f2));
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		axr(`OFS_FLAGS, d, r);
		chk(d, 32'h0);
		axr(8'h40, d, r);
		chk({d[31:2], r}, {30'h0, `RESP_SLVERR});
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < 4; i++) begin
				a = i ? $urandom : 16'h0f09;
				m = $urandom;
				b = i ? $urandom : 16'hffff;
				f = (i ? $urandom : 16'hffff) & 16'h0fd5;
				nar = $urandom;
				axw(`OFS_GPR, a);
				axw(`OFS_FLAGS, f);
				axw(`OFS_MEM, m);
				axw(`OFS_CTRL, {15'h0, nar});
				FM.q.push_back(opc[k]);
				if (k == 2) FM.q.push_back(8'h0a);
				if (k > 4) FM.q.push_back((k == 7) ? 8'h10 : 8'hd0);
				if (k > 2) FM.q.push_back(b[7:0]);
				if (k == 4 || k == 7) FM.q.push_back(b[15:8]);
				if (k == 6) b[15:8] = {8{b[7]}};
				e = exp_f(k, a, m, b, f);
				n = 0;
				do begin
					@(posedge clk_in);
					if (!fr && !done) n++;
				end while (!done);
				chk(n, (k == 7 && nar) ? 20 : nc[k]);
				axr(`OFS_GPR, d, r);
				chk(d, {16'h0, e[47:32]});
				axr(`OFS_MEM, d, r);
				chk(d, {16'h0, e[31:16]});
				axr(`OFS_FLAGS, d, r);
				chk(d, {16'h0, e[15:0]});
			end
		end
		for (int j = 0; j < 2; j++) begin
			FM.q.push_back(j ? 8'hd5 : 8'h80);
			FM.q.push_back(j ? 8'h0b : 8'hd8);
			wait (FM.q.size() == 0);
			repeat (3) @(posedge clk_in);
			axr(`OFS_STATUS, d, r);
			chk(d & 32'h2, 32'h2);
			axw(`OFS_STATUS, 16'h0002);
		end
		complete_run();
	end
endmodule : test_bcd_adjust_add_carry_decode
`default_nettype wire
